// ---- charger_control_logic.v ----
// Charger control logic: source selection, charge state machine, fault latch,
// power-fail and interrupt open-drain outputs, APB register file.
// Comparator inputs are asynchronous levels from analog stages; APB is on pclk.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "charger_defs.vh"

module charger_control_logic #(
   parameter [31:0] debounce_cycles = `DEBOUNCE_CYC,
   parameter [31:0] usb_delay_cycles = `USB_DELAY_CYC,
   parameter [47:0] precharge_cycles = `PRECHG_CYC,
   parameter [47:0] fast_cycles = `FAST_CYC,
   parameter [47:0] taper_cycles = `TAPER_CYC
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire adapter_valid,
   input wire usb_valid,
   input wire adapter_overvoltage,
   input wire battery_low,
   input wire temp_out_of_range,
   input wire taper_detected,
   input wire battery_replaced,
   input wire undervoltage_lockout,
   input wire overtemp_warning,
   input wire cover_present,
   input wire regulator_low,
   output reg power_switch_on,
   output reg select_adapter,
   output reg usb_high_current,
   output reg precharge_mode,
   output reg detect_current_on,
   output reg [1:0] adapter_current_set,
   output reg power_fail_n_out,
   output reg power_fail_n_oe_n,
   output reg int_n_out,
   output reg int_n_oe_n,
   output reg irq
);

   // ----------------------------------------
   // Input synchronisers and debounce
   // ----------------------------------------
   localparam N_IN = 11;
   wire [N_IN-1:0] raw_in;
   reg [N_IN-1:0] sync1_reg;
   reg [N_IN-1:0] sync2_reg;
   reg [N_IN-1:0] deb_reg;
   reg [31:0] deb_cnt_reg [0:N_IN-1];
   integer i;

   assign raw_in = {regulator_low, cover_present, overtemp_warning, undervoltage_lockout, battery_replaced,
                    taper_detected, temp_out_of_range, battery_low, adapter_overvoltage, usb_valid, adapter_valid};

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= `IN_RESET;
         sync2_reg <= `IN_RESET;
      end
      else
      begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // A level must hold for the full debounce time before the filtered copy follows it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Cover starts as present so no false power fail follows reset
         deb_reg <= `IN_RESET;
         for (i = 0; i < N_IN; i = i + 1)
            deb_cnt_reg[i] <= 32'h0;
      end
      else
      begin
         for (i = 0; i < N_IN; i = i + 1)
         begin
            if (sync2_reg[i] == deb_reg[i])
               deb_cnt_reg[i] <= 32'h0;
            else if (deb_cnt_reg[i] >= debounce_cycles - 32'h1)
            begin
               deb_reg[i] <= sync2_reg[i];
               deb_cnt_reg[i] <= 32'h0;
            end
            else
               deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h1;
         end
      end
   end

   wire ac_ok = deb_reg[0];
   wire usb_ok = deb_reg[1];
   wire ac_ovp = deb_reg[2];
   wire bat_low = deb_reg[3];
   wire temp_bad = deb_reg[4];
   wire taper = deb_reg[5];
   wire replaced = deb_reg[6];
   wire undervoltage_lockout_low = deb_reg[7];
   wire ot_warn = deb_reg[8];
   wire cover_ok = deb_reg[9];
   wire reg_low = deb_reg[10];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] charger_config_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_mask_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [2:0] resume_reg;
   reg [31:0] delay_cnt_reg;
   reg [47:0] safety_cnt_reg;
   reg [47:0] taper_cnt_reg;
   reg replaced_d_reg;
   reg reg_low_d_reg;

   wire apb_write = psel & penable & pwrite & pready;
   wire apb_setup = psel & ~penable;
   wire fault_clr_wr = apb_write & (paddr == `OFS_FAULT_CLEAR) & pwdata[0];
   wire replace_edge = replaced & ~replaced_d_reg;
   wire timers_on = charger_config_reg[`CFG_TIMER_EN];

   // Adapter wins whenever both are valid and adapter is not overvolted
   wire ac_usable = ac_ok & ~ac_ovp;
   wire use_ac = ac_usable;
   wire use_usb = ~ac_usable & usb_ok & ~charger_config_reg[`CFG_USB_DIS];
   wire source_ok = (use_ac | use_usb) & ~charger_config_reg[`CFG_CHG_DIS];
   // A source swap restarts from off, so a move to USB passes the delay again
   wire src_changed = use_ac ^ select_adapter;

   // Counter compare, used for all three timers
   function expired;
      input [47:0] cnt;
      input [47:0] lim;
      begin
         expired = (cnt >= lim - 48'h1);
      end
   endfunction

   // ----------------------------------------
   // Charge state machine
   // ----------------------------------------
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         `ST_OFF:
            if (source_ok)
               state_next = use_usb ? `ST_USB_DELAY : (bat_low ? `ST_PRECHARGE : `ST_FAST);
         `ST_USB_DELAY:
            if (!source_ok || !use_usb)
               state_next = `ST_OFF;
            else if (delay_cnt_reg >= usb_delay_cycles - 32'h1)
               state_next = bat_low ? `ST_PRECHARGE : `ST_FAST;
         `ST_PRECHARGE:
            if (!source_ok || src_changed)
               state_next = `ST_OFF;
            else if (temp_bad)
               state_next = `ST_SUSPEND;
            else if (!bat_low)
               state_next = `ST_FAST;
            else if (expired(safety_cnt_reg, precharge_cycles))
               state_next = `ST_FAULT;
         `ST_FAST:
            if (!source_ok || src_changed)
               state_next = `ST_OFF;
            else if (temp_bad)
               state_next = `ST_SUSPEND;
            else if (timers_on && taper && expired(taper_cnt_reg, taper_cycles))
               state_next = `ST_DONE;
            else if (timers_on && !taper && expired(safety_cnt_reg, fast_cycles))
               state_next = `ST_FAULT;
         `ST_SUSPEND:
            if (!source_ok || src_changed)
               state_next = `ST_OFF;
            else if (!temp_bad)
               state_next = resume_reg;
         `ST_FAULT:
            if (fault_clr_wr || replace_edge)
               state_next = `ST_OFF;
         `ST_DONE:
            if (!source_ok || bat_low || replace_edge)
               state_next = `ST_OFF;
         default:
            state_next = `ST_OFF;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= `ST_OFF;
         resume_reg <= `ST_FAST;
         delay_cnt_reg <= 32'h0;
         safety_cnt_reg <= 48'h0;
         taper_cnt_reg <= 48'h0;
         replaced_d_reg <= 1'b0;
         reg_low_d_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         replaced_d_reg <= replaced;
         reg_low_d_reg <= reg_low;
         if (state_next == `ST_SUSPEND && state_reg != `ST_SUSPEND)
            resume_reg <= state_reg;
         delay_cnt_reg <= (state_reg == `ST_USB_DELAY) ? delay_cnt_reg + 32'h1 : 32'h0;
         // Timers hold while suspended and restart when a new phase begins; in fast charge with timers on, the taper timer also restarts whenever taper is low
         if (state_reg == `ST_SUSPEND)
         begin
            safety_cnt_reg <= safety_cnt_reg;
            taper_cnt_reg <= taper_cnt_reg;
         end
         else if (state_next != state_reg && state_next != `ST_SUSPEND)
         begin
            safety_cnt_reg <= 48'h0;
            taper_cnt_reg <= 48'h0;
         end
         else if (state_reg == `ST_PRECHARGE)
            safety_cnt_reg <= safety_cnt_reg + 48'h1;
         else if (state_reg == `ST_FAST && timers_on)
         begin
            safety_cnt_reg <= safety_cnt_reg + 48'h1;
            taper_cnt_reg <= taper ? taper_cnt_reg + 48'h1 : 48'h0;
         end
      end
   end

   // ----------------------------------------
   // Interrupt status, mask and APB
   // ----------------------------------------
   wire fault_evt = (state_next == `ST_FAULT) & (state_reg != `ST_FAULT);
   wire done_evt = (state_next == `ST_DONE) & (state_reg != `ST_DONE);
   wire reglow_evt = reg_low & ~reg_low_d_reg;
   wire [2:0] irq_set = {reglow_evt, done_evt, fault_evt};
   wire [2:0] irq_clr = (apb_write && paddr == `OFS_IRQ_STATUS) ? pwdata[2:0] : 3'h0;
   wire [2:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         charger_config_reg <= `CFG_RESET;
         irq_status_reg <= `IRQ_RESET;
         irq_mask_reg <= 3'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         irq_status_reg <= irq_status_next;
         pready <= apb_setup;
         if (apb_setup)
         begin
            pslverr <= (paddr != `OFS_CONFIG) && (paddr != `OFS_STATUS) && (paddr != `OFS_IRQ_STATUS) &&
                       (paddr != `OFS_IRQ_MASK) && (paddr != `OFS_FAULT_CLEAR);
            case (paddr)
               `OFS_CONFIG: prdata <= {24'h0, charger_config_reg};
               `OFS_STATUS: prdata <= {23'h0, cover_ok, temp_bad, bat_low, use_usb, use_ac, 
                                       (state_reg == `ST_FAULT), state_reg};
               `OFS_IRQ_STATUS: prdata <= {29'h0, irq_status_reg};
               `OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
               default: prdata <= 32'h0;
            endcase
         end
         else
         begin
            pslverr <= 1'b0;
         end
         if (apb_write && paddr == `OFS_CONFIG)
            charger_config_reg <= pwdata[7:0];
         if (apb_write && paddr == `OFS_IRQ_MASK)
            irq_mask_reg <= pwdata[2:0];
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   wire charging = (state_next == `ST_PRECHARGE) || (state_next == `ST_FAST);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         power_switch_on <= 1'b0;
         select_adapter <= 1'b0;
         usb_high_current <= 1'b0;
         precharge_mode <= 1'b0;
         detect_current_on <= 1'b0;
         adapter_current_set <= 2'h0;
         power_fail_n_out <= 1'b0;
         power_fail_n_oe_n <= 1'b1;
         int_n_out <= 1'b0;
         int_n_oe_n <= 1'b1;
         irq <= 1'b0;
      end
      else
      begin
         power_switch_on <= charging & ~(temp_bad | ac_ovp & use_ac);
         select_adapter <= use_ac;
         usb_high_current <= use_usb & charger_config_reg[`CFG_USB_500];
         precharge_mode <= (state_next == `ST_PRECHARGE);
         detect_current_on <= (state_next == `ST_FAULT);
         // Scaling only reaches the adapter current stage
         adapter_current_set <= use_ac ? charger_config_reg[`CFG_SCALE_HI:`CFG_SCALE_LO] : 2'h0;
         power_fail_n_oe_n <= ~(undervoltage_lockout_low | ot_warn | ~cover_ok);
         int_n_oe_n <= ~|(irq_status_next & irq_mask_reg);
         irq <= |(irq_status_next & irq_mask_reg);
      end
   end

endmodule // charger_control_logic

// ---- charger_defs.vh ----
// Constants of the charger control logic: register offsets, field positions, reset values, timing counts.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
`ifndef CHARGER_DEFS_VH
`define CHARGER_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CONFIG 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_FAULT_CLEAR 12'h010

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CFG_USB_500 0
`define CFG_USB_DIS 1
`define CFG_SCALE_LO 2
`define CFG_SCALE_HI 3
`define CFG_TIMER_EN 5
`define CFG_CHG_DIS 6
`define CFG_RESET 8'h00

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_FAULT 0
`define IRQ_DONE 1
`define IRQ_REG_LOW 2
`define IRQ_RESET 3'h0

// ----------------------------------------
// Charge controller states
// ----------------------------------------
`define ST_OFF 3'h0
`define ST_USB_DELAY 3'h1
`define ST_PRECHARGE 3'h2
`define ST_FAST 3'h3
`define ST_SUSPEND 3'h4
`define ST_FAULT 3'h5
`define ST_DONE 3'h6

// ----------------------------------------
// Timing counts (cycles at 200 MHz)
// ----------------------------------------
`define CLK_MHZ 200
`define DEBOUNCE_US 10
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define USB_DELAY_MS 100
`define USB_DELAY_CYC (`USB_DELAY_MS * 1000 * `CLK_MHZ)
`define PRECHG_MIN 30
// Sized terms keep the product from wrapping at 32 bits
`define PRECHG_CYC (`PRECHG_MIN * 48'h3C * 48'hF4240 * `CLK_MHZ)
`define FAST_MIN 300
`define FAST_CYC (`FAST_MIN * 48'h3C * 48'hF4240 * `CLK_MHZ)
`define TAPER_MIN 30
`define TAPER_CYC (`TAPER_MIN * 48'h3C * 48'hF4240 * `CLK_MHZ)

// Idle levels of the filtered inputs: cover in place, all else low
`define IN_RESET 11'h200

`endif

// ---- charger_properties.sv ----
// Checker for the charger control logic, bound to its top-level ports.
// Windows assume the short debounce count of 4 used by the bench.
`timescale 1ns/1ps

module charger_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire adapter_overvoltage,
   input wire temp_out_of_range,
   input wire cover_present,
   input wire power_switch_on,
   input wire select_adapter,
   input wire detect_current_on,
   input wire [1:0] adapter_current_set,
   input wire power_fail_n_out,
   input wire int_n_out,
   input wire power_fail_n_oe_n,
   input wire int_n_oe_n,
   input wire irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_next_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   error_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   irq_pin_a: assert property (irq == !int_n_oe_n)
      else $error("interrupt pin and level differ");
   pins_low_a: assert property (!power_fail_n_out && !int_n_out)
      else $error("open-drain level not low");
   temp_off_a: assert property (temp_out_of_range[*8] ##1 temp_out_of_range[*4] |-> !power_switch_on)
      else $error("switch on while temperature bad");
   overvolt_off_a: assert property (adapter_overvoltage[*8] ##1 adapter_overvoltage[*4] |-> !(power_switch_on && select_adapter))
      else $error("adapter charging in overvoltage");
   cover_fail_a: assert property (!cover_present[*8] ##1 !cover_present[*4] |-> !power_fail_n_oe_n)
      else $error("power fail not driven");
   detect_only_a: assert property (detect_current_on |-> !power_switch_on)
      else $error("switch on during fault");
   scale_usb_a: assert property (!select_adapter[*3] |-> adapter_current_set == 2'h0)
      else $error("scale applied off adapter");
endmodule // charger_checker

// ---- supply_model.sv ----
// Far-side model: wall adapter, USB supply and battery pack as comparator levels.
// Assumes the bench commands each level; a level moves only after a pclk edge.
`timescale 1ns/1ps

module supply_model (
   input wire pclk,
   input wire [10:0] cmd,
   output reg [10:0] lines
);
   // Bits: 0 adapter, 1 USB, 2 overvoltage, 3 low cell, 4 temperature, 5 taper,
   // 6 replacement, 7 lockout, 8 overtemp, 9 cover, 10 regulator low
   initial lines = 11'h200;
   // Registered so a level never changes in the step of the edge that samples it
   always @(posedge pclk)
   begin
      lines <= cmd;
   end
endmodule // supply_model

// ---- testbench.sv ----
// Self-checking bench for the charger control logic over APB.
// Assumes the design header, supply model and checker are compiled first.
`timescale 1ns/1ps
`include "charger_defs.vh"

module testbench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [10:0] cmd = 11'h200;
   reg [31:0] rd;
   reg err;
   integer fails = 0;
   integer compares = 0;
   integer i;
   wire [10:0] lines;
   wire [7:0] outs;
   wire [1:0] scale;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;

   always #2.5 pclk = ~pclk;

   supply_model u_supply_model (.pclk(pclk), .cmd(cmd), .lines(lines));

   charger_control_logic #(.debounce_cycles(32'h4), .usb_delay_cycles(32'h14), .precharge_cycles(48'h3C),
      .fast_cycles(48'h50), .taper_cycles(48'h32)) u_charger_control_logic (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adapter_valid(lines[0]), .usb_valid(lines[1]), .adapter_overvoltage(lines[2]), .battery_low(lines[3]),
      .temp_out_of_range(lines[4]), .taper_detected(lines[5]), .battery_replaced(lines[6]),
      .undervoltage_lockout(lines[7]), .overtemp_warning(lines[8]), .cover_present(lines[9]),
      .regulator_low(lines[10]), .power_switch_on(outs[0]), .select_adapter(outs[1]),
      .usb_high_current(outs[2]), .precharge_mode(outs[3]), .detect_current_on(outs[4]),
      .adapter_current_set(scale), .power_fail_n_out(), .power_fail_n_oe_n(outs[5]), .int_n_out(),
      .int_n_oe_n(outs[6]), .irq(outs[7]));

   task check(input [31:0] seen, input [31:0] want);
   begin
      compares = compares + 1;
      if (seen !== want)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   end
   endtask

   // An idle edge first, so psel is never assigned twice in one time step
   task apb(input wr, input [11:0] a, input [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task rd_chk(input [11:0] a, input [31:0] m, input [31:0] w);
   begin
      apb(1'b0, a, 32'h0);
      check(rd & m, w);
   end
   endtask

   task out_chk(input [7:0] m, input [7:0] w);
   begin
      check({24'h0, outs & m}, {24'h0, w});
   end
   endtask

   // Covers sync, debounce and two stages of state and output registers
   task settle;
   begin
      repeat (14) @(posedge pclk);
   end
   endtask

   task complete_run;
   begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask

   initial
   begin
      #40000;
      fails = fails + 1;
      complete_run;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      out_chk(8'hFF, 8'h60);
      rd_chk(`OFS_CONFIG, 32'hFFFFFFFF, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      check({31'h0, err}, 32'h1);
      $display("test reset done");
      cmd <= 11'h201;
      settle;
      out_chk(8'h0B, 8'h03);
      rd_chk(`OFS_STATUS, 32'h17, 32'h13);
      cmd <= 11'h203;
      settle;
      out_chk(8'h03, 8'h03);
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(1'b1, `OFS_CONFIG, i << 2);
         repeat (2) @(posedge pclk);
         check({30'h0, scale}, i);
      end
      apb(1'b1, `OFS_CONFIG, 32'h0);
      cmd <= 11'h213;
      settle;
      out_chk(8'h01, 8'h00);
      rd_chk(`OFS_STATUS, 32'h87, 32'h84);
      cmd <= 11'h203;
      settle;
      out_chk(8'h01, 8'h01);
      $display("test adapter done");
      cmd <= 11'h207;
      settle;
      out_chk(8'h03, 8'h00);
      rd_chk(`OFS_STATUS, 32'h7, 32'h1);
      repeat (30) @(posedge pclk);
      out_chk(8'h07, 8'h01);
      apb(1'b1, `OFS_CONFIG, 32'h1);
      repeat (2) @(posedge pclk);
      out_chk(8'h04, 8'h04);
      apb(1'b1, `OFS_CONFIG, 32'h3);
      repeat (4) @(posedge pclk);
      out_chk(8'h01, 8'h00);
      cmd <= 11'h203;
      settle;
      out_chk(8'h03, 8'h03);
      apb(1'b1, `OFS_CONFIG, 32'h40);
      repeat (4) @(posedge pclk);
      out_chk(8'h01, 8'h00);
      apb(1'b1, `OFS_CONFIG, 32'h0);
      $display("test usb done");
      cmd <= 11'h208;
      settle;
      cmd <= 11'h209;
      settle;
      out_chk(8'h0B, 8'h0B);
      repeat (70) @(posedge pclk);
      out_chk(8'h11, 8'h10);
      rd_chk(`OFS_STATUS, 32'hF, 32'hD);
      rd_chk(`OFS_IRQ_STATUS, 32'h1, 32'h1);
      out_chk(8'hC0, 8'h40);
      apb(1'b1, `OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge pclk);
      out_chk(8'hC0, 8'h80);
      apb(1'b1, `OFS_FAULT_CLEAR, 32'h1);
      repeat (2) @(posedge pclk);
      out_chk(8'h10, 8'h00);
      apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      out_chk(8'hC0, 8'h40);
      repeat (70) @(posedge pclk);
      out_chk(8'h10, 8'h10);
      cmd <= 11'h249;
      settle;
      out_chk(8'h10, 8'h00);
      $display("test fault done");
      for (i = 0; i < 3; i = i + 1)
      begin
         cmd <= 11'h201 ^ (11'h080 << i);
         settle;
         out_chk(8'h20, 8'h00);
         cmd <= 11'h201;
         settle;
         out_chk(8'h20, 8'h20);
      end
      cmd <= 11'h601;
      settle;
      rd_chk(`OFS_IRQ_STATUS, 32'h4, 32'h4);
      out_chk(8'h80, 8'h80);
      $display("test pins done");
      apb(1'b1, `OFS_CONFIG, 32'h20);
      repeat (90) @(posedge pclk);
      rd_chk(`OFS_STATUS, 32'h7, 32'h5);
      apb(1'b1, `OFS_FAULT_CLEAR, 32'h1);
      cmd <= 11'h221;
      repeat (70) @(posedge pclk);
      rd_chk(`OFS_STATUS, 32'h7, 32'h6);
      rd_chk(`OFS_IRQ_STATUS, 32'h2, 32'h2);
      $display("test timers done");
      complete_run;
   end
endmodule // testbench

bind charger_control_logic charger_checker u_charger_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .adapter_overvoltage(adapter_overvoltage),
   .temp_out_of_range(temp_out_of_range), .cover_present(cover_present), .power_switch_on(power_switch_on),
   .select_adapter(select_adapter), .detect_current_on(detect_current_on),
   .adapter_current_set(adapter_current_set), .power_fail_n_out(power_fail_n_out), .int_n_out(int_n_out),
   .power_fail_n_oe_n(power_fail_n_oe_n), .int_n_oe_n(int_n_oe_n), .irq(irq));
